//--- rtl/nca_defines.svh
// Constants of the NAND column address host controller
`ifndef NCA_DEFINES_SVH
`define NCA_DEFINES_SVH
// Software register offsets (byte addresses)
`define NCA_REG_CTRL 8'h00
`define NCA_REG_COL 8'h04
`define NCA_REG_ROW 8'h08
`define NCA_REG_DATA 8'h0C
`define NCA_REG_DREQ 8'h10
`define NCA_REG_STAT 8'h14
`define NCA_REG_ORIG 8'h18
// Control register fields
`define NCA_CTRL_MULTI 2
`define NCA_CTRL_PROG 3
// Status register fields
`define NCA_STAT_ERR 4
// Row address bit positions of die and plane select
`define NCA_DIE_BIT 18
`define NCA_PLANE_BIT 6
// Flash opcodes
`define NCA_OPC_RD1 8'h05
`define NCA_OPC_RD2 8'h06
`define NCA_OPC_IN 8'h85
`define NCA_OPC_CONF 8'hE0
`define NCA_OPC_SEL 8'h78
// Timing: clock period and waits in ns
`define NCA_CLK_NS 25
`define NCA_T_WHR_NS 100
`define NCA_T_ADL_NS 100
`define NCA_WHR_CYC ((`NCA_T_WHR_NS + `NCA_CLK_NS - 1) / `NCA_CLK_NS)
`define NCA_ADL_CYC ((`NCA_T_ADL_NS + `NCA_CLK_NS - 1) / `NCA_CLK_NS)
// Bus cycle phases: strobe low and high lengths in clocks
`define NCA_PH_LOW 2
`define NCA_PH_HIGH 2
`endif

//--- rtl/nca_pkg.sv
// Types of the NAND column address host controller
package nca_pkg;
  // Column operation selected by software
  typedef enum logic [1:0] {
    OP_RD05 = 2'b00,
    OP_RD06 = 2'b01,
    OP_IN2  = 2'b10,
    OP_IN5  = 2'b11
  } nca_op_e;
  // Kind of one flash bus cycle
  typedef enum logic [1:0] {
    CK_CMD  = 2'b00,
    CK_ADR  = 2'b01,
    CK_DIN  = 2'b10,
    CK_DOUT = 2'b11
  } nca_kind_e;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEL  = 3'b001,
    S_SROW = 3'b010,
    S_OPC  = 3'b011,
    S_COL  = 3'b100,
    S_ROW  = 3'b101,
    S_CONF = 3'b110,
    S_DATA = 3'b111
  } nca_st_e;
  // Flash pins driven by the host
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       io_oe;
    logic [7:0] io_o;
  } nca_pin_s;
endpackage : nca_pkg

//--- rtl/nca_tmr.sv
// Down counter for host wait intervals
`timescale 1ns/100ps
`default_nettype none
module nca_tmr #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  output logic              done
);
  import nca_pkg::*;
  logic [W-1:0] cnt_r;   // Cycles left
  logic [W-1:0] cnt_nxt; // Next count

  // Load or count down to zero
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Register the count
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == '0); // Wait elapsed
endmodule : nca_tmr
`default_nettype wire

//--- rtl/nca_cyc.sv
// One flash bus cycle: command, address, data in or data out
`timescale 1ns/100ps
`default_nettype none
`include "nca_defines.svh"
module nca_cyc (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire nca_pkg::nca_kind_e  kind,
  input  wire logic [7:0]          wbyte,
  input  wire logic [7:0]          io_i,
  output nca_pkg::nca_pin_s        pin,
  output logic                     busy,
  output logic                     done,
  output logic [7:0]               rbyte
);
  import nca_pkg::*;
  localparam logic [2:0] PH_LAST = 3'(`NCA_PH_LOW + `NCA_PH_HIGH);
  localparam logic [2:0] PH_LOW  = 3'(`NCA_PH_LOW);
  nca_pin_s   pin_r,   pin_nxt;   // Pin flops
  logic       busy_r,  busy_nxt;  // Cycle in progress
  logic [2:0] ph_r,    ph_nxt;    // Phase counter
  nca_kind_e  kind_r,  kind_nxt;  // Kind held for the cycle
  logic [7:0] rbyte_r, rbyte_nxt; // Captured read byte

  // Phase sequencing: setup, strobe low, strobe high
  always_comb begin
    busy_nxt  = busy_r;
    ph_nxt    = ph_r;
    kind_nxt  = kind_r;
    rbyte_nxt = rbyte_r;
    pin_nxt   = pin_r;
    if (!busy_r && start) begin
      busy_nxt     = 1'b1;
      ph_nxt       = 3'h0;
      kind_nxt     = kind;
      pin_nxt.io_o = wbyte;
    end else if (busy_r) begin
      ph_nxt = ph_r + 3'h1;
      // Sample read data at the end of the low phase
      if (ph_r == PH_LOW && kind_r == CK_DOUT) begin
        rbyte_nxt = io_i;
      end
      if (ph_r == PH_LAST) begin
        busy_nxt = 1'b0;
      end
    end
    // Pin levels follow the next phase
    pin_nxt.cle   = busy_nxt && kind_nxt == CK_CMD;
    pin_nxt.ale   = busy_nxt && kind_nxt == CK_ADR;
    pin_nxt.io_oe = busy_nxt && kind_nxt != CK_DOUT;
    pin_nxt.we_n  = !(busy_nxt && kind_nxt != CK_DOUT && ph_nxt != 3'h0 && ph_nxt <= PH_LOW);
    pin_nxt.re_n  = !(busy_nxt && kind_nxt == CK_DOUT && ph_nxt != 3'h0 && ph_nxt <= PH_LOW);
  end

  // Register the cycle state and pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_r  <= 1'b0;
      ph_r    <= 3'h0;
      kind_r  <= CK_CMD;
      rbyte_r <= 8'h00;
      pin_r   <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe: 1'b0, io_o: 8'h00};
    end else begin
      busy_r  <= busy_nxt;
      ph_r    <= ph_nxt;
      kind_r  <= kind_nxt;
      rbyte_r <= rbyte_nxt;
      pin_r   <= pin_nxt;
    end
  end

  assign pin   = pin_r;
  assign busy  = busy_r;
  assign done  = busy_r && ph_r == PH_LAST; // Last clock of the cycle
  assign rbyte = rbyte_r;

  // Write strobe stays low exactly two clocks
  property p_we_width;
    @(posedge mclk) disable iff (rst)
      $fell(pin_r.we_n) |-> ##1 !pin_r.we_n ##1 pin_r.we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
endmodule : nca_cyc
`default_nettype wire

//--- rtl/nca_host.sv
// Host sequencer for NAND column address operations
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "nca_defines.svh"
module nca_host (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [7:0]   sw_addr,
  input  wire logic [31:0]  sw_wdata,
  input  wire logic         sw_wr,
  input  wire logic         sw_rd,
  output logic [31:0]       sw_rdata,
  input  wire logic         rb_n,
  input  wire logic [7:0]   io_i,
  output nca_pkg::nca_pin_s pin,
  output logic              ce_n
);
  import nca_pkg::*;

  // Software register state
  nca_op_e     op_r,    op_nxt;    // Selected operation
  logic        multi_r, multi_nxt; // Target has several dies
  logic        prog_r,  prog_nxt;  // Program sequence open
  logic [15:0] col_r,   col_nxt;   // Column address
  logic [23:0] row_r,   row_nxt;   // Row address
  logic [23:0] orig_r,  orig_nxt;  // Original program row
  logic [7:0]  wdat_r,  wdat_nxt;  // Byte to write
  logic [31:0] rdat_r,  rdat_nxt;  // Read data flop
  logic        rb_q_r;             // All dies ready, sampled
  // Sequencer state
  nca_st_e     st_r,    st_nxt;    // Sequencer state
  logic [1:0]  idx_r,   idx_nxt;   // Address cycle index
  logic        fired_r, fired_nxt; // Cycle launched for state
  logic        omode_r, omode_nxt; // Data output mode
  logic        imode_r, imode_nxt; // Data input mode
  logic        err_r,   err_nxt;   // Sticky refusal flag
  logic        sel_r,   sel_nxt;   // 78h sent this sequence
  logic        dir_r,   dir_nxt;   // Data cycle is a read
  logic [7:0]  rbuf_r,  rbuf_nxt;  // Last byte read
  logic        ce_n_r,  ce_n_nxt;  // Chip enable flop
  // Strobe decodes
  logic        go;                 // Control write
  logic        dw_req;             // Data write request
  logic        dr_req;             // Data read request
  logic        clr_err;            // Error clear request
  nca_op_e     go_op;              // Operation being written
  logic        go_prog;            // Program open bit being written
  logic        mism;               // Die or plane mismatch
  // Engine and timer links
  logic        e_start, e_busy, e_done;
  nca_kind_e   e_kind;
  logic [7:0]  e_byte, e_rbyte;
  logic        t_ld, t_done;
  logic [7:0]  t_val;

  // Decoding of software strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
    hit = s && (a == off);
  endfunction : hit

  assign go      = hit(sw_addr, `NCA_REG_CTRL, sw_wr);
  assign dw_req  = hit(sw_addr, `NCA_REG_DATA, sw_wr);
  assign dr_req  = hit(sw_addr, `NCA_REG_DREQ, sw_wr);
  assign clr_err = hit(sw_addr, `NCA_REG_STAT, sw_wr) && sw_wdata[`NCA_STAT_ERR];
  assign go_op   = nca_op_e'(sw_wdata[1:0]);
  assign go_prog = sw_wdata[`NCA_CTRL_PROG];
  // Inserted destination must keep die and plane
  assign mism = (row_r[`NCA_DIE_BIT] != orig_r[`NCA_DIE_BIT]) ||
                (row_r[`NCA_PLANE_BIT] != orig_r[`NCA_PLANE_BIT]);

  // Register writes and read data mux
  always_comb begin
    op_nxt    = op_r;
    multi_nxt = multi_r;
    prog_nxt  = prog_r;
    col_nxt   = col_r;
    row_nxt   = row_r;
    orig_nxt  = orig_r;
    wdat_nxt  = wdat_r;
    rdat_nxt  = 32'h0000_0000;
    if (sw_wr) begin
      case (sw_addr)
        `NCA_REG_CTRL: begin
          op_nxt    = (st_r == S_IDLE) ? go_op : op_r; // Held while a sequence runs
          multi_nxt = (st_r == S_IDLE) ? sw_wdata[`NCA_CTRL_MULTI] : multi_r;
          prog_nxt  = (st_r == S_IDLE) ? go_prog : prog_r;
        end
        `NCA_REG_COL:  col_nxt  = sw_wdata[15:0];  // Any cache byte
        `NCA_REG_ROW:  row_nxt  = sw_wdata[23:0];
        `NCA_REG_ORIG: orig_nxt = sw_wdata[23:0];
        `NCA_REG_DATA: wdat_nxt = sw_wdata[7:0];
        default: ;
      endcase
    end
    if (sw_rd) begin
      case (sw_addr)
        `NCA_REG_CTRL: rdat_nxt = {28'h0000000, prog_r, multi_r, op_r};
        `NCA_REG_COL:  rdat_nxt = {16'h0000, col_r};
        `NCA_REG_ROW:  rdat_nxt = {8'h00, row_r};
        `NCA_REG_ORIG: rdat_nxt = {8'h00, orig_r};
        `NCA_REG_DATA: rdat_nxt = {24'h000000, rbuf_r};
        `NCA_REG_STAT: rdat_nxt = {26'h0000000, rb_q_r, err_r, t_done, imode_r, omode_r, st_r != S_IDLE};
        default:       rdat_nxt = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      op_r    <= OP_RD05;
      multi_r <= 1'b0;
      prog_r  <= 1'b0;
      col_r   <= 16'h0000;
      row_r   <= 24'h000000;
      orig_r  <= 24'h000000;
      wdat_r  <= 8'h00;
      rdat_r  <= 32'h0000_0000;
      rb_q_r  <= 1'b0;
    end else begin
      op_r    <= op_nxt;
      multi_r <= multi_nxt;
      prog_r  <= prog_nxt;
      col_r   <= col_nxt;
      row_r   <= row_nxt;
      orig_r  <= orig_nxt;
      wdat_r  <= wdat_nxt;
      rdat_r  <= rdat_nxt;
      rb_q_r  <= rb_n;
    end
  end

  // Byte sent in the cycle of each state
  function automatic logic [7:0] cyc_byte(input nca_st_e s, input logic [1:0] i, input nca_op_e o,
                                          input logic [15:0] c, input logic [23:0] r, input logic [7:0] d);
    case (s)
      S_SEL:   cyc_byte = `NCA_OPC_SEL;
      S_SROW,
      S_ROW:   cyc_byte = r[{i, 3'b000} +: 8];
      S_COL:   cyc_byte = c[{i[0], 3'b000} +: 8];
      S_CONF:  cyc_byte = `NCA_OPC_CONF;
      S_DATA:  cyc_byte = d;
      S_OPC: begin
        case (o)
          OP_RD05: cyc_byte = `NCA_OPC_RD1; // Column only
          OP_RD06: cyc_byte = `NCA_OPC_RD2; // Plane switch
          default: cyc_byte = `NCA_OPC_IN;  // Both input forms
        endcase
      end
      default: cyc_byte = 8'h00;
    endcase
  endfunction : cyc_byte

  // Sequencer next state
  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    fired_nxt = fired_r;
    omode_nxt = omode_r;
    imode_nxt = imode_r;
    err_nxt   = err_r;
    sel_nxt   = sel_r;
    dir_nxt   = dir_r;
    rbuf_nxt  = rbuf_r;
    t_ld      = 1'b0;
    t_val     = 8'(`NCA_WHR_CYC);
    e_start   = 1'b0;
    e_kind    = CK_CMD;
    e_byte    = cyc_byte(st_r, idx_r, op_r, col_r, row_r, wdat_r);
    if (clr_err) begin
      err_nxt = 1'b0;
    end
    case (st_r)
      S_IDLE: begin
        if (go) begin
          // Any new command ends the present data mode
          omode_nxt = 1'b0;
          imode_nxt = 1'b0;
          sel_nxt   = 1'b0;
          idx_nxt   = 2'd0;
          if (go_op[1] && !go_prog) begin
            err_nxt = 1'b1; // No open program
          end else if (go_op == OP_IN5 && mism) begin
            err_nxt = 1'b1; // Refused
          end else if ((go_op == OP_RD05 && sw_wdata[`NCA_CTRL_MULTI]) ||
                       (go_op == OP_RD06 && !rb_q_r)) begin
            st_nxt = S_SEL; // Select one die first
          end else begin
            st_nxt = S_OPC; // Single-die 05h, 06h with all ready, or input: no select needed
          end
        end else if (dw_req) begin
          if (imode_r && t_done) begin
            st_nxt  = S_DATA; // Patch cache bytes
            dir_nxt = 1'b0;
          end else begin
            err_nxt = 1'b1;
          end
        end else if (dr_req) begin
          if (omode_r && t_done) begin
            st_nxt  = S_DATA; // Read only after the wait
            dir_nxt = 1'b1;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      S_SEL: begin
        if (e_done) begin
          st_nxt  = S_SROW;
          idx_nxt = 2'd0;
          sel_nxt = 1'b1;
        end
      end
      S_SROW: begin
        e_kind = CK_ADR;
        if (e_done) begin
          idx_nxt = idx_r + 2'd1;
          if (idx_r == 2'd2) begin
            st_nxt  = S_OPC;
            idx_nxt = 2'd0;
          end
        end
      end
      S_OPC: begin
        if (e_done) begin
          st_nxt = S_COL;
        end
      end
      S_COL: begin
        e_kind = CK_ADR;
        if (e_done) begin
          idx_nxt = idx_r + 2'd1;
          if (idx_r == 2'd1) begin
            idx_nxt = 2'd0;
            case (op_r)
              OP_RD05: st_nxt = S_CONF;
              OP_IN2: begin
                // Two cycles keep the destination
                st_nxt    = S_IDLE;
                imode_nxt = 1'b1;
                t_ld      = 1'b1;
                t_val     = 8'(`NCA_ADL_CYC);
              end
              default: st_nxt = S_ROW;
            endcase
          end
        end
      end
      S_ROW: begin
        e_kind = CK_ADR;
        if (e_done) begin
          idx_nxt = idx_r + 2'd1;
          if (idx_r == 2'd2) begin
            idx_nxt = 2'd0;
            if (op_r == OP_IN5) begin
              // Fifth cycle moves the destination
              st_nxt    = S_IDLE;
              imode_nxt = 1'b1;
              t_ld      = 1'b1;
              t_val     = 8'(`NCA_ADL_CYC);
            end else begin
              st_nxt = S_CONF;
            end
          end
        end
      end
      S_CONF: begin
        if (e_done) begin
          // Output mode from the addressed column
          st_nxt    = S_IDLE;
          omode_nxt = 1'b1;
          t_ld      = 1'b1;
          t_val     = 8'(`NCA_WHR_CYC);
        end
      end
      S_DATA: begin
        e_kind = dir_r ? CK_DOUT : CK_DIN;
        if (e_done) begin
          st_nxt = S_IDLE;
          if (dir_r) begin
            rbuf_nxt = e_rbyte;
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    // Requests while busy are refused; set wins over clear
    if (st_r != S_IDLE && (go || dw_req || dr_req)) begin
      err_nxt = 1'b1;
    end
    // One bus cycle at a time; address states launch one per index
    if (st_r != S_IDLE && !e_busy && !fired_r) begin
      e_start   = 1'b1;
      fired_nxt = 1'b1;
    end
    if (e_done) begin
      fired_nxt = 1'b0;
    end
    ce_n_nxt = !(st_nxt != S_IDLE || omode_nxt || imode_nxt);
  end

  // Sequencer flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r    <= S_IDLE;
      idx_r   <= 2'd0;
      fired_r <= 1'b0;
      omode_r <= 1'b0;
      imode_r <= 1'b0;
      err_r   <= 1'b0;
      sel_r   <= 1'b0;
      dir_r   <= 1'b0;
      rbuf_r  <= 8'h00;
      ce_n_r  <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      fired_r <= fired_nxt;
      omode_r <= omode_nxt;
      imode_r <= imode_nxt;
      err_r   <= err_nxt;
      sel_r   <= sel_nxt;
      dir_r   <= dir_nxt;
      rbuf_r  <= rbuf_nxt;
      ce_n_r  <= ce_n_nxt;
    end
  end

  // Bus cycle engine
  nca_cyc u_cyc (
    .mclk  (mclk),
    .rst   (rst),
    .start (e_start),
    .kind  (e_kind),
    .wbyte (e_byte),
    .io_i  (io_i),
    .pin   (pin),
    .busy  (e_busy),
    .done  (e_done),
    .rbyte (e_rbyte)
  );

  // Wait interval timer
  nca_tmr #(.W(8)) u_tmr (
    .mclk (mclk),
    .rst  (rst),
    .load (t_ld),
    .val  (t_val),
    .done (t_done)
  );

  assign sw_rdata = rdat_r;
  assign ce_n     = ce_n_r;

  property p_whr;
    @(posedge mclk) disable iff (rst)
      (e_start && st_r == S_DATA && dir_r) |-> (omode_r && t_done);
  endproperty
  a_whr: assert property (p_whr) else $error("read before wait");
  property p_adl;
    @(posedge mclk) disable iff (rst)
      (e_start && st_r == S_DATA && !dir_r) |-> (imode_r && t_done);
  endproperty
  a_adl: assert property (p_adl) else $error("write before wait");
  property p_conf;
    @(posedge mclk) disable iff (rst)
      (st_r == S_CONF && e_done) |=> (omode_r && !t_done && st_r == S_IDLE && !ce_n);
  endproperty
  a_conf: assert property (p_conf) else $error("no output mode");
  property p_sel06;
    @(posedge mclk) disable iff (rst)
      (e_start && st_r == S_OPC && op_r == OP_RD06) |-> (rb_q_r || sel_r);
  endproperty
  a_sel06: assert property (p_sel06) else $error("06h without select");
  property p_sel05;
    @(posedge mclk) disable iff (rst)
      (e_start && st_r == S_OPC && op_r == OP_RD05 && multi_r) |-> sel_r;
  endproperty
  a_sel05: assert property (p_sel05) else $error("05h without select");
  property p_prog;
    @(posedge mclk) disable iff (rst)
      (go && st_r == S_IDLE && go_op[1] && !go_prog) |=> (err_r && st_r == S_IDLE) ##1 (st_r == S_IDLE);
  endproperty
  a_prog: assert property (p_prog) else $error("input outside program");
  property p_die;
    @(posedge mclk) disable iff (rst)
      (go && st_r == S_IDLE && go_op == OP_IN5 && go_prog && mism) |=> (err_r && st_r == S_IDLE);
  endproperty
  a_die: assert property (p_die) else $error("die or plane mismatch");
  property p_in5;
    @(posedge mclk) disable iff (rst)
      (st_r == S_ROW && e_done && idx_r == 2'd2 && op_r == OP_IN5) |=> (imode_r && !omode_r && !t_done);
  endproperty
  a_in5: assert property (p_in5) else $error("no input mode after row");
endmodule : nca_host
`default_nettype wire

//--- testbench/nca_dev_model.sv
// Behavioural flash target answering the column address host
`timescale 1ns/100ps
`default_nettype none
module nca_dev_model
  import nca_pkg::*;
(
  input  wire nca_pkg::nca_pin_s pin,
  input  wire logic              ce_n,
  input  wire logic              lun_rdy,
  input  wire logic              arr_rdy,
  output logic                   rb_n,
  output logic [7:0]             io_i,
  output logic [7:0]             prev_op,
  output logic [23:0]            dest_row,
  output logic                   out_mode
);
  logic [7:0]  cache [4096];  // Cache register bytes
  logic [7:0]  op_q;          // Latest opcode
  logic [7:0]  last_q;        // Last byte driven
  logic [15:0] col;           // Column pointer
  logic [23:0] row;           // Row being gathered
  logic [2:0]  acnt;          // Address cycles seen
  logic        in_mode;       // Data input mode
  logic        drv;           // Output driver on
  // Power-up state
  initial begin
    op_q = 8'h00;
    prev_op = 8'h00;
    last_q = 8'h00;
    col = 16'h0000;
    row = 24'h000000;
    dest_row = 24'h000000;
    acnt = 3'h0;
    in_mode = 1'b0;
    out_mode = 1'b0;
  end
  assign rb_n = lun_rdy;
  assign drv  = out_mode && !ce_n && !pin.re_n;
  // Released bus shows inverse of last byte
  assign io_i = drv ? cache[col[11:0]] : ~last_q;
  // Read strobe end steps the pointer
  always @(posedge pin.re_n) begin
    if (out_mode && !ce_n) begin
      last_q = cache[col[11:0]];
      col    = col + 16'h0001;
    end
  end
  // Command, address and data latch on write strobe
  always @(posedge pin.we_n) begin
    if (!ce_n && pin.cle) begin
      if (pin.io_o == 8'hE0) begin
        out_mode = (op_q == 8'h05 && acnt == 3'h2 && lun_rdy) ||
                   (op_q == 8'h06 && acnt == 3'h5 && lun_rdy && arr_rdy);
      end else begin
        out_mode = 1'b0;
      end
      if (pin.io_o == 8'h05 || pin.io_o == 8'h06) prev_op = op_q;
      op_q    = pin.io_o;
      acnt    = 3'h0;
      in_mode = 1'b0;
    end else if (!ce_n && pin.ale) begin
      if (acnt < 3'h2) col = acnt[0] ? {pin.io_o, col[7:0]} : {col[15:8], pin.io_o};
      else row = {pin.io_o, row[23:8]};
      acnt = acnt + 3'h1;
      if (op_q == 8'h85 && acnt == 3'h2) in_mode = lun_rdy;
      if (op_q == 8'h85 && acnt == 3'h5) dest_row = row;
    end else if (!ce_n && in_mode && pin.io_oe) begin
      cache[col[11:0]] = pin.io_o;
      col = col + 16'h0001;
    end
  end
endmodule : nca_dev_model
`default_nettype wire

//--- testbench/nca_host_tb_top.sv
// Self-checking bench of the column address host
`timescale 1ns/100ps
`default_nettype none
`include "nca_defines.svh"
module nca_host_tb_top;
  import nca_pkg::*;
  // One input then read-back case
  typedef struct packed {
    logic [1:0]  in_op;
    logic [1:0]  rd_op;
    logic        multi;
    logic        ar;
    logic [15:0] col;
    logic [23:0] row;
    logic [7:0]  dat;
  } nca_row_s;
  localparam nca_row_s rows [4] = '{
    '{2'h2, 2'h0, 1'b0, 1'b0, 16'h0000, 24'h000000, 8'hA5},
    '{2'h3, 2'h1, 1'b0, 1'b1, 16'h0FFF, 24'h040040, 8'h3C},
    '{2'h2, 2'h0, 1'b1, 1'b1, 16'h0123, 24'h000000, 8'h5A},
    '{2'h3, 2'h0, 1'b0, 1'b1, 16'h0800, 24'h000100, 8'hC3}};
  logic        mclk;
  logic        rst;
  logic [7:0]  sw_addr;
  logic [31:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [31:0] sw_rdata;
  logic        rb_n;
  logic [7:0]  io_i;
  nca_pin_s    pin;
  logic        ce_n;
  logic        lun_rdy;
  logic        arr_rdy;
  logic [7:0]  prev_op;
  logic [23:0] dest_row;
  logic        out_mode;
  logic [31:0] rv;          // Last read word
  int          fail_count;
  int          num_checks;
  nca_host u_nca_host (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .rb_n(rb_n), .io_i(io_i), .pin(pin), .ce_n(ce_n));
  nca_dev_model u_nca_dev_model (.pin(pin), .ce_n(ce_n), .lun_rdy(lun_rdy), .arr_rdy(arr_rdy), .rb_n(rb_n),
    .io_i(io_i), .prev_op(prev_op), .dest_row(dest_row), .out_mode(out_mode));
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge mclk);
    sw_wr    <= 1'b0;
  endtask : wr
  // Data stand in the cycle after the strobe; taken at its closing edge
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge mclk);
    sw_rd   <= 1'b0;
    @(posedge mclk);
    rv = sw_rdata;
  endtask : rd
  // Wait for idle and, if asked, the elapsed wait
  task automatic poll(input logic need);
    int n;
    n = 0;
    do begin
      rd(`NCA_REG_STAT);
      n++;
    end while ((rv[0] !== 1'b0 || (need && rv[3] !== 1'b1)) && n < 300);
    if (rv[0] !== 1'b0 || (need && rv[3] !== 1'b1)) fail_count++;
  endtask : poll
  task automatic go(input logic [31:0] c, input logic need);
    wr(`NCA_REG_CTRL, c);
    repeat (3) @(posedge mclk);
    poll(need);
  endtask : go
  task automatic err_is(input logic e);
    rd(`NCA_REG_STAT);
    chk({31'h0, rv[4]}, {31'h0, e});
    wr(`NCA_REG_STAT, 32'h10);
  endtask : err_is
  task automatic stop_test;
    $display("checks=%0d fails=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Hang guard
  initial begin
    #1_000_000;
    fail_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    lun_rdy = 1'b1;
    arr_rdy = 1'b1;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({19'h0, pin}, 32'h0000_0600);
    chk({31'h0, ce_n}, 32'h1);
    // Patch a byte, then read it back
    foreach (rows[i]) begin
      wr(`NCA_REG_ROW, {8'h00, rows[i].row});
      wr(`NCA_REG_ORIG, {8'h00, rows[i].row});
      wr(`NCA_REG_COL, {16'h0000, rows[i].col});
      go({28'h0, 2'b10, rows[i].in_op}, 1'b1);
      if (rows[i].in_op == 2'h3) chk({8'h0, dest_row}, {8'h0, rows[i].row});
      wr(`NCA_REG_DATA, {24'h0, rows[i].dat});
      poll(1'b0);
      arr_rdy <= rows[i].ar;
      go({28'h0, 1'b1, rows[i].multi, rows[i].rd_op}, 1'b1);
      chk({31'h0, out_mode}, 32'h1);
      if (rows[i].multi) chk({24'h0, prev_op}, 32'h78);
      wr(`NCA_REG_DREQ, 32'h0);
      poll(1'b0);
      rd(`NCA_REG_DATA);
      chk(rv, {24'h0, rows[i].dat});
      arr_rdy <= 1'b1;
    end
    // Input with no open program is refused
    wr(`NCA_REG_CTRL, 32'h2);
    err_is(1'b1);
    err_is(1'b0);
    // Die bit differing from the original row is refused
    wr(`NCA_REG_ROW, 32'h0004_0000);
    wr(`NCA_REG_ORIG, 32'h0);
    wr(`NCA_REG_CTRL, 32'hB);
    err_is(1'b1);
    // Plane read while busy gets a die select first
    lun_rdy <= 1'b0;
    @(posedge mclk);
    go(32'h9, 1'b0);
    chk({24'h0, prev_op}, 32'h78);
    chk({31'h0, out_mode}, 32'h0);
    chk({31'h0, ce_n}, 32'h0);
    lun_rdy <= 1'b1;
    // Reset in mid-run drops the data mode and chip enable
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({31'h0, ce_n}, 32'h1);
    rd(`NCA_REG_STAT);
    chk(rv, 32'h0000_0028);
    stop_test();
  end
endmodule : nca_host_tb_top
`default_nettype wire
